// >>> verif/char_pattern_gen_test.sv
`timescale 1ns/1ns
// =========================================================
// request stream bench for the pattern lookup block
module char_pattern_gen_test;
   import char_pattern_pkg::*;
   logic        core_clk = 1'b0;
   logic        srst = 1'b1;
   logic        full_ram_pattern_mode = 1'b0;
   logic        text_disp_on = 1'b1;
   logic        graphic_disp_on = 1'b0;
   logic [2:0]  combine_mode = 3'h0;
   logic [15:0] graphic_home = 16'h1400;
   logic        offset_wr = 1'b0;
   logic [7:0]  offset_wr_data = 8'h00;
   logic        blink_phase = 1'b0;
   logic        req_valid = 1'b0;
   char_req_t   req = '0;
   logic        out_ready = 1'b0;
   logic [1:0]  delay = 2'h0;
   logic        req_ready_q, ram_rd_en_q, ram_rd_valid, out_valid_q, attr_mode_q, graphic_pixels_on_q;
   logic [15:0] ram_addr_q;
   logic [7:0]  ram_rd_data, p, a;
   logic [4:0]  pattern_offset_bits_q;
   pix_out_t    out_q, w;
   logic [15:0] seen_q[$];
   logic [7:0]  attrs[7] = '{8'h00, 8'h05, 8'h03, 8'h08, 8'h0d, 8'h0b, 8'hf5};
   // expected effects per attribute: blink, reverse, inhibit
   logic [2:0]  fx_exp[7] = '{3'b000, 3'b010, 3'b001, 3'b100, 3'b110, 3'b001, 3'b010};
   int          err_count = 0;
   int          num_checks = 0;

   char_pattern_gen uut (.core_clk, .srst, .full_ram_pattern_mode, .text_disp_on, .graphic_disp_on,
      .combine_mode, .graphic_home, .offset_wr, .offset_wr_data, .blink_phase, .req_valid,
      .req_ready_q, .req, .ram_rd_en_q, .ram_addr_q, .ram_rd_valid, .ram_rd_data, .out_valid_q,
      .out_ready, .out_q, .pattern_offset_bits_q, .attr_mode_q, .graphic_pixels_on_q);
   ram_model ram (.core_clk, .srst, .rd_en(ram_rd_en_q), .addr(ram_addr_q), .delay,
      .rd_valid(ram_rd_valid), .rd_data(ram_rd_data));

   // clock and read address log
   always #50 core_clk = ~core_clk;
   always @(negedge core_clk) if (ram_rd_en_q === 1'b1) seen_q.push_back(ram_addr_q);

   // =========================================================
   // helpers
   function automatic logic [7:0] hash(input logic [15:0] x);
      return x[7:0] ^ x[15:8];
   endfunction
   function automatic logic [15:0] pat_addr(input logic [7:0] c, input logic [2:0] r);
      return {5'h15, full_ram_pattern_mode ? c[7] : 1'b1, c[6:0], r};
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, s, e);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic fail_wait();
      err_count++;
      $display("Error at %0t: wait ran out", $time);
      tally_and_finish();
   endtask
   // hold request until ready seen, then release
   task automatic send(input logic [7:0] c, input logic [15:0] x, input logic [2:0] r);
      int i;
      @(negedge core_clk);
      req = '{code: c, index: x, row: r};
      req_valid = 1'b1;
      for (i = 0; i < 40 && req_ready_q !== 1'b1; i++) @(negedge core_clk);
      if (i == 40) fail_wait();
      @(negedge core_clk);
      req_valid = 1'b0;
   endtask
   task automatic recv(output pix_out_t o);
      int i;
      @(negedge core_clk);
      out_ready = 1'b1;
      for (i = 0; i < 40 && out_valid_q !== 1'b1; i++) @(negedge core_clk);
      if (i == 40) fail_wait();
      o = out_q;
      @(negedge core_clk);
      out_ready = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] c, input logic [15:0] x, input logic [2:0] r, input pix_out_t e);
      seen_q.delete();
      send(c, x, r);
      recv(w);
      chk(w, e);
   endtask

   // =========================================================
   // main sequence
   initial begin
      repeat (6) @(negedge core_clk);
      chk(ram_addr_q, 16'h0000);
      chk({req_ready_q, out_valid_q, ram_rd_en_q, out_q, pattern_offset_bits_q}, 0);
      srst = 1'b0;
      offset_wr = 1'b1;
      offset_wr_data = 8'hf5;
      @(negedge core_clk) offset_wr = 1'b0;
      @(negedge core_clk);
      chk(pattern_offset_bits_q, 5'h15);
      $display("test offset done");
      // rom plus ram mode: high codes from ram, low codes from rom
      xfer(8'h85, 16'h0, 3'h3, {hash(pat_addr(8'h85, 3'h3)), 3'h0});
      chk(seen_q[0], pat_addr(8'h85, 3'h3));
      xfer(8'h41, 16'h0, 3'h7, 11'h000);
      chk(seen_q.size(), 0);
      $display("test rom_plus_ram done");
      // full ram mode: user pattern of eight rows, all codes from ram
      full_ram_pattern_mode = 1'b1;
      for (int r = 0; r < 8; r++) ram.mem[pat_addr(8'h41, r[2:0])] = 8'h80 >> r;
      for (int r = 0; r < 8; r++) begin
         xfer(8'h41, 16'h0, r[2:0], {8'h80 >> r, 3'h0});
         chk(seen_q[0], pat_addr(8'h41, r[2:0]));
      end
      xfer(8'hc1, 16'h0, 3'h7, {hash(pat_addr(8'hc1, 3'h7)), 3'h0});
      chk(seen_q[0], {5'h15, 11'h60f});
      $display("test full_ram done");
      // attributes: graphics off, home, data, text only, graphics on
      delay = 2'h3;
      for (int n = 0; n < 8; n++) ram.mem[16'h1400 + n] = n < 7 ? attrs[n] : 8'h08;
      combine_mode = 3'h4;
      graphic_disp_on = 1'b1;
      repeat (2) @(negedge core_clk);
      chk(attr_mode_q, 1'b1);
      chk(graphic_pixels_on_q, 1'b0);
      p = hash(pat_addr(8'h22, 3'h1));
      for (int n = 0; n < 7; n++) begin
         a = fx_exp[n];
         xfer(8'h22, n, 3'h1, {a[0] ? 8'h00 : a[1] ? ~p : p, a[2:0]});
         chk(seen_q[0], 16'h1400 + n);
      end
      blink_phase = 1'b1;
      xfer(8'h22, 16'h7, 3'h1, {8'h00, 3'b100});
      blink_phase = 1'b0;
      combine_mode = 3'h0;
      repeat (2) @(negedge core_clk);
      chk(graphic_pixels_on_q, 1'b1);
      chk(attr_mode_q, 1'b0);
      text_disp_on = 1'b0;
      xfer(8'h22, 16'h0, 3'h1, 11'h000);
      text_disp_on = 1'b1;
      $display("test attribute done");
      // receiver stalls: two words buffered, third held, order kept
      delay = 2'h0;
      for (int c = 1; c < 4; c++) send(c, 16'h0, 3'h0);
      repeat (10) @(negedge core_clk);
      chk(req_ready_q, 1'b0);
      for (int c = 1; c < 4; c++) begin
         recv(w);
         chk(w, {hash(pat_addr(c, 3'h0)), 3'h0});
      end
      repeat (3) @(negedge core_clk);
      chk(out_valid_q, 1'b0);
      chk(req_ready_q, 1'b1);
      $display("test stall done");
      tally_and_finish();
   end
endmodule

// >>> verif/ram_model.sv
`timescale 1ns/1ns
// =========================================================
// display ram at the far side, one read at a time, set delay
module ram_model (
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        rd_en,
   input  wire logic [15:0] addr,
   input  wire logic [1:0]  delay,
   output logic             rd_valid,
   output logic [7:0]       rd_data
);
   logic [7:0]  mem [logic [15:0]];
   logic [15:0] addr_q;
   logic [1:0]  cnt_q;
   logic        pend_q;

   // unwritten bytes read back as an address hash
   function automatic logic [7:0] peek(input logic [15:0] a);
      return mem.exists(a) ? mem[a] : (a[7:0] ^ a[15:8]);
   endfunction

   // answer after delay; data line toggles while not valid
   always_ff @(posedge core_clk) begin
      rd_valid <= 1'b0;
      if (srst) begin
         pend_q  <= 1'b0;
         rd_data <= 8'h00;
      end else if (rd_en) begin
         pend_q  <= 1'b1;
         cnt_q   <= delay;
         addr_q  <= addr;
         rd_data <= ~rd_data;
      end else if (pend_q && cnt_q == 2'h0) begin
         rd_valid <= 1'b1;
         rd_data  <= peek(addr_q);
         pend_q   <= 1'b0;
      end else begin
         cnt_q   <= cnt_q - 2'h1;
         rd_data <= ~rd_data;
      end
   end
endmodule

// >>> verilog/char_pattern_gen.sv
`timescale 1ns/1ns
`include "char_pattern_regs.svh"
// =========================================================
// character pattern lookup and text attribute logic
module char_pattern_gen (
   input  wire logic                          core_clk,
   input  wire logic                          srst,
   input  wire logic                          full_ram_pattern_mode,
   input  wire logic                          text_disp_on,
   input  wire logic                          graphic_disp_on,
   input  wire logic [2:0]                    combine_mode,
   input  wire logic [15:0]                   graphic_home,
   input  wire logic                          offset_wr,
   input  wire logic [7:0]                    offset_wr_data,
   input  wire logic                          blink_phase,
   input  wire logic                          req_valid,
   output logic                               req_ready_q,
   input  wire char_pattern_pkg::char_req_t   req,
   output logic                               ram_rd_en_q,
   output logic [15:0]                        ram_addr_q,
   input  wire logic                          ram_rd_valid,
   input  wire logic [7:0]                    ram_rd_data,
   output logic                               out_valid_q,
   input  wire logic                          out_ready,
   output char_pattern_pkg::pix_out_t         out_q,
   output logic [4:0]                         pattern_offset_bits_q,
   output logic                               attr_mode_q,
   output logic                               graphic_pixels_on_q
);
   import char_pattern_pkg::*;

   fetch_state_t state_q;
   fetch_state_t state_d;
   char_req_t    req_q;
   logic [7:0]   attr_q;
   logic         attr_mode;
   logic         use_rom;
   logic         pat_from_rom_q;
   logic         rom_rd_en;
   logic [7:0]   rom_data;
   logic [15:0]  pat_addr;
   logic         fx_blink;
   logic         fx_reverse;
   logic         fx_inhibit;
   pix_out_t     push_data;
   pix_out_t     push_data_q;
   logic         push_valid;
   logic         buf_in_ready;
   pix_out_t     skid_q;
   logic         skid_valid_q;

   // =========================================================
   // configuration
   // text only combining means graphic bytes are attributes
   assign attr_mode = (combine_mode == `COMBINE_TEXT_ONLY);

   // offset register keeps its low five bits until rewritten
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pattern_offset_bits_q <= `OFFSET_RESET;
      end else if (offset_wr) begin
         pattern_offset_bits_q <= offset_wr_data[`OFFSET_MSB:0];
      end
   end

   // display mode flags seen by the pixel path
   always_ff @(posedge core_clk) begin
      if (srst) begin
         attr_mode_q         <= 1'b0;
         graphic_pixels_on_q <= 1'b0;
      end else begin
         attr_mode_q         <= attr_mode;
         graphic_pixels_on_q <= graphic_disp_on & ~attr_mode;
      end
   end

   // =========================================================
   // pattern source and address
   // rom only for codes with top bit clear, and only in rom plus ram mode
   assign use_rom = ~full_ram_pattern_mode & ~req_q.code[`CODE_MSB_POS];

   // offset, code (bit 10 forced in rom plus ram mode), row
   assign pat_addr = {pattern_offset_bits_q,
                      full_ram_pattern_mode ? req_q.code[`CODE_MSB_POS] : `ROM_AREA_BIT,
                      req_q.code[6:0],
                      req_q.row};

   assign rom_rd_en = (state_q == ST_PAT_ISSUE) & use_rom;

   pattern_rom u_rom (
      .core_clk  (core_clk),
      .srst      (srst),
      .rd_en     (rom_rd_en),
      .rd_addr   ({req_q.code[6:0], req_q.row}),
      .rd_data_q (rom_data)
   );

   // =========================================================
   // fetch sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (req_valid & req_ready_q) begin
               state_d = attr_mode ? ST_ATTR_WAIT : ST_PAT_ISSUE;
            end
         end
         ST_ATTR_WAIT: begin
            if (ram_rd_valid) begin
               state_d = ST_PAT_ISSUE;
            end
         end
         ST_PAT_ISSUE: begin
            state_d = ST_PAT_WAIT;
         end
         ST_PAT_WAIT: begin
            if (pat_from_rom_q | ram_rd_valid) begin
               state_d = ST_PUSH;
            end
         end
         ST_PUSH: begin
            if (buf_in_ready) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // request acceptance, ready only while idle
   always_ff @(posedge core_clk) begin
      if (srst) begin
         req_ready_q <= 1'b0;
         req_q       <= '0;
      end else begin
         req_ready_q <= (state_d == ST_IDLE);
         if (req_valid & req_ready_q) begin
            req_q <= req;
         end
      end
   end

   // ram read port, one cycle read pulse per fetch
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ram_rd_en_q <= 1'b0;
         ram_addr_q  <= `ADDR_RESET;
      end else begin
         ram_rd_en_q <= 1'b0;
         if ((state_q == ST_IDLE) & req_valid & req_ready_q & attr_mode) begin
            ram_rd_en_q <= 1'b1;
            ram_addr_q  <= graphic_home + req.index;
         end else if ((state_q == ST_PAT_ISSUE) & ~use_rom) begin
            ram_rd_en_q <= 1'b1;
            ram_addr_q  <= pat_addr;
         end
      end
   end

   // attribute byte, normal when attributes are off
   always_ff @(posedge core_clk) begin
      if (srst) begin
         attr_q <= `BYTE_ZERO;
      end else if ((state_q == ST_IDLE) & req_valid & req_ready_q) begin
         attr_q <= `BYTE_ZERO;
      end else if ((state_q == ST_ATTR_WAIT) & ram_rd_valid) begin
         attr_q <= ram_rd_data;
      end
   end

   // remembers which source answers the pattern fetch
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pat_from_rom_q <= 1'b0;
      end else if (state_q == ST_PAT_ISSUE) begin
         pat_from_rom_q <= use_rom;
      end
   end

   // =========================================================
   // attribute decode and pattern shaping
   // only the low nibble counts; inhibit dominates
   assign fx_inhibit = attr_q[`ATTR_INHIBIT_POS];
   assign fx_reverse = attr_q[`ATTR_REVERSE_POS] & attr_q[`ATTR_LOW_POS] & ~fx_inhibit;
   assign fx_blink   = attr_q[`ATTR_BLINK_POS] & ~fx_inhibit;

   // captured row with effects applied
   always_ff @(posedge core_clk) begin
      if (srst) begin
         push_data_q <= '0;
      end else if (state_q == ST_PAT_WAIT) begin
         if (~text_disp_on | fx_inhibit | (fx_blink & blink_phase)) begin
            push_data_q.pattern <= `BYTE_ZERO;
         end else if (fx_reverse) begin
            push_data_q.pattern <= pat_from_rom_q ? ~rom_data : ~ram_rd_data;
         end else begin
            push_data_q.pattern <= pat_from_rom_q ? rom_data : ram_rd_data;
         end
         push_data_q.blink   <= fx_blink;
         push_data_q.reverse <= fx_reverse;
         push_data_q.inhibit <= fx_inhibit;
      end
   end

   assign push_valid = (state_q == ST_PUSH);
   assign push_data  = push_data_q;

   // =========================================================
   // two-entry buffer: output register plus skid register
   assign buf_in_ready = ~skid_valid_q;

   // output stage, refilled from skid first to keep order
   always_ff @(posedge core_clk) begin
      if (srst) begin
         out_valid_q <= 1'b0;
         out_q       <= '0;
      end else if (~out_valid_q | out_ready) begin
         if (skid_valid_q) begin
            out_valid_q <= 1'b1;
            out_q       <= skid_q;
         end else begin
            out_valid_q <= push_valid;
            out_q       <= push_data;
         end
      end
   end

   // skid stage catches a word pushed while the receiver stalls
   // a full skid empties into the output stage; a push from the sequencer waits meanwhile
   always_ff @(posedge core_clk) begin
      if (srst) begin
         skid_valid_q <= 1'b0;
         skid_q       <= '0;
      end else if (out_valid_q & ~out_ready) begin
         if (push_valid & buf_in_ready) begin
            skid_valid_q <= 1'b1;
            skid_q       <= push_data;
         end
      end else if (skid_valid_q) begin
         skid_valid_q <= 1'b0;
      end
   end

   // =========================================================
   // checks
   property p_offset_hold;
      @(posedge core_clk) disable iff (srst)
      !offset_wr |=> $stable(pattern_offset_bits_q);
   endproperty
   a_offset_hold: assert property (p_offset_hold) else $error("offset changed without a write");

   property p_offset_load;
      @(posedge core_clk) disable iff (srst)
      offset_wr |=> pattern_offset_bits_q == $past(offset_wr_data[4:0]);
   endproperty
   a_offset_load: assert property (p_offset_load) else $error("offset not loaded from low bits");

   property p_no_rom_in_full_ram;
      @(posedge core_clk) disable iff (srst)
      (state_q == ST_PAT_ISSUE) & full_ram_pattern_mode |=> ram_rd_en_q & !pat_from_rom_q;
   endproperty
   a_no_rom_in_full_ram: assert property (p_no_rom_in_full_ram) else $error("rom used in full ram mode");

   property p_high_codes_from_ram;
      @(posedge core_clk) disable iff (srst)
      (state_q == ST_PAT_ISSUE) & req_q.code[7] |=> ram_rd_en_q;
   endproperty
   a_high_codes_from_ram: assert property (p_high_codes_from_ram) else $error("high code not from ram");

   property p_low_codes_from_rom;
      @(posedge core_clk) disable iff (srst)
      (state_q == ST_PAT_ISSUE) & !full_ram_pattern_mode & !req_q.code[7] |=> !ram_rd_en_q & pat_from_rom_q;
   endproperty
   a_low_codes_from_rom: assert property (p_low_codes_from_rom) else $error("low code not from rom");

   property p_pat_addr_layout;
      @(posedge core_clk) disable iff (srst)
      (state_q == ST_PAT_ISSUE) & !use_rom |=>
         ram_addr_q[15:11] == $past(pattern_offset_bits_q) && ram_addr_q[2:0] == $past(req_q.row) &&
         ram_addr_q[9:3] == $past(req_q.code[6:0]);
   endproperty
   a_pat_addr_layout: assert property (p_pat_addr_layout) else $error("pattern address misformed");

   property p_rom_mode_bit10;
      @(posedge core_clk) disable iff (srst)
      (state_q == ST_PAT_ISSUE) & !use_rom & !full_ram_pattern_mode |=> ram_addr_q[10];
   endproperty
   a_rom_mode_bit10: assert property (p_rom_mode_bit10) else $error("bit 10 clear in rom plus ram mode");

   property p_attr_addr;
      @(posedge core_clk) disable iff (srst)
      (state_q == ST_IDLE) & req_valid & req_ready_q & attr_mode |=>
         ram_rd_en_q && ram_addr_q == $past(graphic_home) + $past(req.index);
   endproperty
   a_attr_addr: assert property (p_attr_addr) else $error("attribute address wrong");

   property p_no_graphic_pixels;
      @(posedge core_clk) disable iff (srst)
      attr_mode |=> !graphic_pixels_on_q ##1 1'b1;
   endproperty
   a_no_graphic_pixels: assert property (p_no_graphic_pixels) else $error("graphic shown in text only mode");

   property p_inhibit_blank;
      @(posedge core_clk) disable iff (srst)
      out_valid_q & out_q.inhibit |-> out_q.pattern == 8'h00 && !out_q.reverse && !out_q.blink;
   endproperty
   a_inhibit_blank: assert property (p_inhibit_blank) else $error("inhibited row not blank");

   property p_out_hold;
      @(posedge core_clk) disable iff (srst)
      out_valid_q & !out_ready |=> out_valid_q && $stable(out_q);
   endproperty
   a_out_hold: assert property (p_out_hold) else $error("output changed under stall");

endmodule

// >>> verilog/char_pattern_pkg.sv
package char_pattern_pkg;

   // character fetch request from the display scanner
   typedef struct packed {
      logic [7:0]  code;
      logic [15:0] index;
      logic [2:0]  row;
   } char_req_t;

   // finished pattern row with its effects
   typedef struct packed {
      logic [7:0] pattern;
      logic       blink;
      logic       reverse;
      logic       inhibit;
   } pix_out_t;

   typedef enum logic [2:0] {
      ST_IDLE      = 3'b000,
      ST_ATTR_WAIT = 3'b001,
      ST_PAT_ISSUE = 3'b010,
      ST_PAT_WAIT  = 3'b011,
      ST_PUSH      = 3'b100
   } fetch_state_t;

endpackage

// >>> verilog/char_pattern_regs.svh
// What this block does
// - full RAM mode: user pattern area is 2048 bytes placed by five offset bits.
// - ROM plus RAM mode: user area is the 1024 bytes with address bit 10 set.
// - each user pattern is eight consecutive bytes, one per row.
// - pattern address is offset, then character code, then row; bit 10 forced in ROM mode.
// - ROM plus RAM mode fetches codes 80h to ffh from the user RAM area.
// - full RAM mode fetches every code from RAM, never from the pattern ROM.
// - attribute of character n is byte n of the graphic area from its home.
// - attribute use means text only combining; graphic bytes never shown as pixels.
// - decode low four attribute bits into normal, reverse, inhibit, blink; ignore upper four.
// - ROM plus RAM mode fetches codes 00h to 7fh from the pattern ROM.
// - combine field with top bit set and low bits clear selects text only.
`ifndef CHAR_PATTERN_REGS_SVH
`define CHAR_PATTERN_REGS_SVH

// =========================================================
// widths and field positions
`define OFFSET_MSB       3'h4
`define ATTR_BLINK_POS   2'h3
`define ATTR_REVERSE_POS 2'h2
`define ATTR_INHIBIT_POS 2'h1
`define ATTR_LOW_POS     2'h0
`define CODE_MSB_POS     3'h7

// =========================================================
// mode values and reset values
`define COMBINE_TEXT_ONLY 3'h4
`define OFFSET_RESET      5'h00
`define ADDR_RESET        16'h0000
`define BYTE_ZERO         8'h00
`define ROM_AREA_BIT      1'b1

`endif

// >>> verilog/pattern_rom.sv
`timescale 1ns/1ns
`include "char_pattern_regs.svh"
// =========================================================
// built-in pattern rom, 128 characters of 8 rows, registered read
module pattern_rom #(
   parameter logic [8191:0] ROM_IMAGE = '0
) (
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic       rd_en,
   input  wire logic [9:0] rd_addr,
   output logic      [7:0] rd_data_q
);
   // read data come from a register, one cycle after rd_en
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rd_data_q <= `BYTE_ZERO;
      end else if (rd_en) begin
         rd_data_q <= ROM_IMAGE[{rd_addr, 3'h0} +: 8];
      end
   end
endmodule
